// ==== include/serial_link_error_monitor_defs.svh ====
// Purpose: offsets, field positions, reset values and counts
// Assumes: register indices; byte address is four times the index
// Notes: definitions only
`ifndef SERIAL_LINK_ERROR_MONITOR_DEFS_SVH
`define SERIAL_LINK_ERROR_MONITOR_DEFS_SVH

`define LANES 8
`define REG_LINK_PAGE 12'h300
`define REG_ERR_DUR 12'h312
`define REG_CGS 12'h470
`define REG_FRAME 12'h471
`define REG_CHKSUM 12'h472
`define REG_ILAS 12'h473
`define REG_QUAL 12'h476
`define REG_TEST 12'h477
`define REG_THR 12'h47c
`define REG_MASK 12'h47d
`define REG_LANE_CTRL 12'h480
`define REG_LANE_HOLD 12'h488
`define REG_LANE_STAT 12'h490
`define REG_IRQ_EN0 12'h4b8
`define REG_IRQ_EN1 12'h4b9
`define REG_IRQ_ST0 12'h4ba
`define REG_IRQ_ST1 12'h4bb
`define REG_LINK_CTRL 12'h4f0

`define LINK_PAGE_BIT 2
`define QUAL_BIT 4
`define TEST_BIT 7
`define ERR_DUR_LSB 4
`define LINK_EN_BIT 0
`define OCT_LSB 4

`define THR_RST 8'hff
`define MASK_RST 3'h7
`define LANE_CTRL_RST 6'h38
`define LINK_CTRL_RST 8'h10

`define CGS_COMMAS 3'h4
`define REINIT_ERRS 3'h4
`define RESYNC_FRAMES 8'h05
`define RESYNC_OCTETS 8'h09
`define OCTETS_PER_CYCLE 8'h04

`endif

// ==== include/serial_link_error_monitor_pkg.sv ====
// Purpose: types shared by the error monitor
// Assumes: eight lanes
// Notes: constants live in the defs header
`default_nettype none
package serial_link_error_monitor_pkg;

    typedef struct packed {
        logic [7:0] comma;
        logic [7:0] disparityError;
        logic [7:0] notInTableError;
        logic [7:0] unexpectedControlCharError;
    } lane_chars_t;

    typedef struct packed {
        logic [7:0] laneActive;
        logic [7:0] frameSync;
        logic [7:0] goodChecksum;
        logic [7:0] ilasPass;
        logic deskewDone;
    } link_status_t;

    typedef struct packed {
        logic [111:0] configured;
        logic [111:0] received;
    } link_cfg_t;

    typedef enum logic [2:0] {
        SYNC_WAIT = 3'b001,
        SYNC_UP = 3'b010,
        SYNC_REINIT = 3'b100
    } sync_state_t;

endpackage
`default_nettype wire

// ==== design/serial_link_error_monitor.sv ====
// Purpose: per-lane error counting, sync request and link test status
// Assumes: lane flags arrive on sys_clk, one flag per lane per cycle
// Notes: APB slave, zero wait states
`include "serial_link_error_monitor_defs.svh"
`default_nettype none
module serial_link_error_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link side
    input wire serial_link_error_monitor_pkg::lane_chars_t laneChars,
    input wire serial_link_error_monitor_pkg::link_status_t linkStatus,
    input wire serial_link_error_monitor_pkg::link_cfg_t linkCfg,
    // Outputs
    output logic syncRequestOut_n,
    output logic irqPending
);

    ////////////////////////////////////////////////////////////////////
    function automatic logic inLaneBank(input logic [11:0] idx,
                                        input logic [11:0] base);
        return idx[11:3] == base[11:3];
    endfunction

    // Half a cycle cannot be made on one edge; it rounds up to one
    function automatic logic [2:0] pulseWidth(input logic [3:0] dur);
        logic [2:0] w;
        w = (dur == 4'h0) ? 3'h1 : ((dur > 4'h7) ? 3'h7 : dur[2:0]);
        return w;
    endfunction

    function automatic logic [7:0] holdCycles(input logic [3:0] f);
        logic [7:0] oct;
        oct = 8'(`RESYNC_FRAMES * {4'h0, f}) + `RESYNC_OCTETS;
        return 8'((oct + `OCTETS_PER_CYCLE - 8'h01) / `OCTETS_PER_CYCLE);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register state
    serial_link_error_monitor_pkg::sync_state_t state_reg, state_next;
    logic linkPage_reg;
    logic [3:0] errDur_reg;
    logic qual_reg;
    logic testMode_reg;
    logic [7:0] thr_reg;
    logic [2:0] mask_reg;
    logic [5:0] laneCtrl_reg [8];
    logic [2:0] laneHold_reg [8];
    logic [2:0] termFlag_reg [8];
    logic [2:0] termFlag_next [8];
    logic [7:0] irqEn0_reg;
    logic irqEn1_reg;
    logic [8:0] irqStat_reg;
    logic [7:0] linkCtrl_reg;
    logic [7:0] errCnt_reg [24];
    logic [7:0] errCnt_next [24];
    logic [2:0] cgsCnt_reg [8];
    logic [2:0] dispSeen_reg [8];
    logic [2:0] nitSeen_reg [8];
    logic [7:0] ilasPass_reg;
    logic [7:0] holdCnt_reg;
    logic [2:0] pulseCnt_reg;
    logic [2:0] pulseCnt_next;
    logic [4:0] linkOkPrev_reg;
    logic syncRequestOut_n_reg;
    logic [31:0] prdata_reg;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    logic [11:0] regIdx;
    logic [2:0] laneSel;
    logic aligned, hitPage, hitDur, hitCgs, hitFrame, hitChk, hitIlas;
    logic hitQual, hitTest, hitThr, hitMask, hitCtrl, hitHold, hitStat;
    logic hitEn0, hitEn1, hitSt0, hitSt1, hitLink, mapped, wrEn, rdSetup;

    assign regIdx = paddr[13:2];
    assign laneSel = paddr[4:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    assign hitPage = aligned && regIdx == `REG_LINK_PAGE;
    assign hitDur = aligned && regIdx == `REG_ERR_DUR;
    assign hitCgs = aligned && regIdx == `REG_CGS;
    assign hitFrame = aligned && regIdx == `REG_FRAME;
    assign hitChk = aligned && regIdx == `REG_CHKSUM;
    assign hitIlas = aligned && regIdx == `REG_ILAS;
    assign hitQual = aligned && regIdx == `REG_QUAL;
    assign hitTest = aligned && regIdx == `REG_TEST;
    assign hitThr = aligned && regIdx == `REG_THR;
    assign hitMask = aligned && regIdx == `REG_MASK;
    assign hitCtrl = aligned && inLaneBank(regIdx, `REG_LANE_CTRL);
    assign hitHold = aligned && inLaneBank(regIdx, `REG_LANE_HOLD);
    assign hitStat = aligned && inLaneBank(regIdx, `REG_LANE_STAT);
    assign hitEn0 = aligned && regIdx == `REG_IRQ_EN0;
    assign hitEn1 = aligned && regIdx == `REG_IRQ_EN1;
    assign hitSt0 = aligned && regIdx == `REG_IRQ_ST0;
    assign hitSt1 = aligned && regIdx == `REG_IRQ_ST1;
    assign hitLink = aligned && regIdx == `REG_LINK_CTRL;
    assign mapped = hitPage | hitDur | hitCgs | hitFrame | hitChk | hitIlas
                  | hitQual | hitTest | hitThr | hitMask | hitCtrl | hitHold
                  | hitStat | hitEn0 | hitEn1 | hitSt0 | hitSt1 | hitLink;
    assign wrEn = psel & penable & pwrite & mapped;
    assign rdSetup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Error qualification and link state
    logic [7:0] active, errVec [3], cgsPass;
    logic [7:0] dispQual;
    logic linkEnable, stateUp, allCgs, reinitTrip, thrTrip, reinitStart;
    logic anyErr, mismatch;
    logic [2:0] thrHit;
    logic [4:0] linkOkNow, linkFell;
    logic [8:0] irqEvent, irqClear, irqEnAll;

    assign active = linkStatus.laneActive;
    assign linkEnable = linkCtrl_reg[`LINK_EN_BIT];
    assign stateUp = state_reg == serial_link_error_monitor_pkg::SYNC_UP;
    assign dispQual = laneChars.disparityError
                    & ~(qual_reg ? laneChars.notInTableError : 8'h00);
    assign errVec[0] = laneChars.unexpectedControlCharError;
    assign errVec[1] = laneChars.notInTableError;
    assign errVec[2] = dispQual;
    assign anyErr = |((errVec[0] | errVec[1] | errVec[2]) & active);
    assign mismatch = linkCfg.configured != linkCfg.received;

    always_comb begin
        cgsPass = 8'h00;
        reinitTrip = 1'b0;
        for (int l = 0; l < `LANES; l++) begin
            cgsPass[l] = cgsCnt_reg[l] == `CGS_COMMAS;
            reinitTrip = reinitTrip | (dispSeen_reg[l] == `REINIT_ERRS)
                       | (nitSeen_reg[l] == `REINIT_ERRS);
        end
    end

    assign allCgs = linkEnable && (|active) && ((cgsPass & active) == active);
    assign thrTrip = |(thrHit & mask_reg);
    assign reinitStart = stateUp & (reinitTrip | thrTrip);

    ////////////////////////////////////////////////////////////////////
    // Error counters
    always_comb begin
        logic [7:0] cnt;
        logic [7:0] nxt;
        logic inc;
        logic clr;
        logic reach;
        cnt = 8'h00;
        nxt = 8'h00;
        inc = 1'b0;
        clr = 1'b0;
        reach = 1'b0;
        thrHit = 3'h0;
        for (int l = 0; l < `LANES; l++) begin
            for (int t = 0; t < 3; t++) begin
                cnt = errCnt_reg[l * 3 + t];
                inc = errVec[t][l] & laneCtrl_reg[l][t + 3];
                clr = laneCtrl_reg[l][t] | reinitStart;
                if (cnt == 8'hff && laneHold_reg[l][t]) begin
                    nxt = cnt;
                end else begin
                    nxt = 8'(cnt + 8'h01);
                end
                if (clr) begin
                    nxt = 8'h00;
                end else if (!inc) begin
                    nxt = cnt;
                end
                reach = inc && !clr && nxt == thr_reg && nxt != cnt;
                thrHit[t] = thrHit[t] | reach;
                errCnt_next[l * 3 + t] = nxt;
                termFlag_next[l][t] = !clr && (termFlag_reg[l][t] | reach);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sync state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            serial_link_error_monitor_pkg::SYNC_WAIT: begin
                if (allCgs) begin
                    state_next = serial_link_error_monitor_pkg::SYNC_UP;
                end
            end
            serial_link_error_monitor_pkg::SYNC_UP: begin
                if (!linkEnable) begin
                    state_next = serial_link_error_monitor_pkg::SYNC_WAIT;
                end else if (reinitStart) begin
                    state_next = serial_link_error_monitor_pkg::SYNC_REINIT;
                end
            end
            serial_link_error_monitor_pkg::SYNC_REINIT: begin
                if (holdCnt_reg <= 8'h01) begin
                    state_next = serial_link_error_monitor_pkg::SYNC_WAIT;
                end
            end
            default: state_next = serial_link_error_monitor_pkg::SYNC_WAIT;
        endcase
    end

    // An error that also forces reinit needs no pulse: the hold covers it
    assign pulseCnt_next = (stateUp && anyErr && !reinitStart)
                         ? pulseWidth(errDur_reg)
                         : ((pulseCnt_reg != 3'h0) ? 3'(pulseCnt_reg - 3'h1) : 3'h0);

    ////////////////////////////////////////////////////////////////////
    // Interrupt status
    assign linkOkNow[0] = (|active) && ((cgsPass & active) == active);
    assign linkOkNow[1] = (linkStatus.frameSync & active) == active;
    assign linkOkNow[2] = (linkStatus.goodChecksum & active) == active;
    assign linkOkNow[3] = (ilasPass_reg & active) == active;
    assign linkOkNow[4] = linkStatus.deskewDone;
    assign linkFell = linkOkPrev_reg & ~linkOkNow;
    assign irqEvent = {mismatch, thrHit, linkFell};
    assign irqEnAll = {irqEn1_reg, irqEn0_reg};
    assign irqClear = {wrEn & hitSt1 & pwdata[0],
                       (wrEn & hitSt0) ? pwdata[7:0] : 8'h00};
    assign irqPending = |irqStat_reg;

    ////////////////////////////////////////////////////////////////////
    // Read mux
    logic [31:0] readData;
    always_comb begin
        readData = 32'h0;
        if (hitPage) readData[`LINK_PAGE_BIT] = linkPage_reg;
        if (hitDur) readData[`ERR_DUR_LSB +: 4] = errDur_reg;
        if (hitCgs) readData[7:0] = cgsPass & active;
        if (hitFrame) readData[7:0] = linkStatus.frameSync & active;
        if (hitChk) readData[7:0] = linkStatus.goodChecksum & active;
        if (hitIlas) readData[7:0] = ilasPass_reg;
        if (hitQual) readData[`QUAL_BIT] = qual_reg;
        if (hitTest) readData[`TEST_BIT] = testMode_reg;
        if (hitThr) readData[7:0] = thr_reg;
        if (hitMask) readData[2:0] = mask_reg;
        if (hitCtrl) readData[5:0] = laneCtrl_reg[laneSel];
        if (hitHold) readData[2:0] = laneHold_reg[laneSel];
        if (hitStat) readData[3:0] = {active[laneSel], termFlag_reg[laneSel]};
        if (hitEn0) readData[7:0] = irqEn0_reg;
        if (hitEn1) readData[0] = irqEn1_reg;
        if (hitSt0) readData[7:0] = irqStat_reg[7:0];
        if (hitSt1) readData[0] = irqStat_reg[8];
        if (hitLink) readData[7:0] = linkCtrl_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            linkPage_reg <= 1'b0;
            errDur_reg <= 4'h0;
            qual_reg <= 1'b0;
            testMode_reg <= 1'b0;
            thr_reg <= `THR_RST;
            mask_reg <= `MASK_RST;
            irqEn0_reg <= 8'h00;
            irqEn1_reg <= 1'b0;
            linkCtrl_reg <= `LINK_CTRL_RST;
            prdata_reg <= 32'h0;
        end else begin
            if (wrEn && hitPage) linkPage_reg <= pwdata[`LINK_PAGE_BIT];
            if (wrEn && hitDur) errDur_reg <= pwdata[`ERR_DUR_LSB +: 4];
            if (wrEn && hitQual) qual_reg <= pwdata[`QUAL_BIT];
            if (wrEn && hitTest) testMode_reg <= pwdata[`TEST_BIT];
            if (wrEn && hitThr) thr_reg <= pwdata[7:0];
            if (wrEn && hitMask && linkPage_reg) mask_reg <= pwdata[2:0];
            if (wrEn && hitEn0) irqEn0_reg <= pwdata[7:0];
            if (wrEn && hitEn1) irqEn1_reg <= pwdata[0];
            if (wrEn && hitLink) linkCtrl_reg <= pwdata[7:0];
            if (rdSetup) prdata_reg <= readData;
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int l = 0; l < `LANES; l++) begin
            if (!rst_n) begin
                laneCtrl_reg[l] <= `LANE_CTRL_RST;
                laneHold_reg[l] <= 3'h0;
                termFlag_reg[l] <= 3'h0;
            end else begin
                if (wrEn && hitCtrl && laneSel == 3'(l)) laneCtrl_reg[l] <= pwdata[5:0];
                if (wrEn && hitHold && laneSel == 3'(l)) laneHold_reg[l] <= pwdata[2:0];
                termFlag_reg[l] <= termFlag_next[l];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 24; i++) begin
            errCnt_reg[i] <= rst_n ? errCnt_next[i] : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link tracking
    always_ff @(posedge sys_clk) begin
        for (int l = 0; l < `LANES; l++) begin
            if (!rst_n || state_next == serial_link_error_monitor_pkg::SYNC_REINIT
                || !linkEnable) begin
                cgsCnt_reg[l] <= 3'h0;
                dispSeen_reg[l] <= 3'h0;
                nitSeen_reg[l] <= 3'h0;
            end else begin
                if (!stateUp) begin
                    cgsCnt_reg[l] <= !laneChars.comma[l] ? 3'h0
                                   : ((cgsCnt_reg[l] == `CGS_COMMAS) ? cgsCnt_reg[l]
                                   : 3'(cgsCnt_reg[l] + 3'h1));
                end
                if (stateUp && dispQual[l] && dispSeen_reg[l] != `REINIT_ERRS) begin
                    dispSeen_reg[l] <= 3'(dispSeen_reg[l] + 3'h1);
                end
                if (stateUp && laneChars.notInTableError[l]
                    && nitSeen_reg[l] != `REINIT_ERRS) begin
                    nitSeen_reg[l] <= 3'(nitSeen_reg[l] + 3'h1);
                end
            end
        end
    end

    // Repeated alignment test re-evaluates every cycle instead of latching
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !stateUp) begin
            ilasPass_reg <= 8'h00;
        end else if (testMode_reg) begin
            ilasPass_reg <= linkStatus.ilasPass & active;
        end else begin
            ilasPass_reg <= ilasPass_reg | (linkStatus.ilasPass & active);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= serial_link_error_monitor_pkg::SYNC_WAIT;
            holdCnt_reg <= 8'h00;
            pulseCnt_reg <= 3'h0;
            syncRequestOut_n_reg <= 1'b0;
            linkOkPrev_reg <= 5'h00;
            irqStat_reg <= 9'h000;
        end else begin
            state_reg <= state_next;
            if (reinitStart) begin
                holdCnt_reg <= holdCycles(linkCtrl_reg[`OCT_LSB +: 4]);
            end else if (holdCnt_reg != 8'h00) begin
                holdCnt_reg <= 8'(holdCnt_reg - 8'h01);
            end
            pulseCnt_reg <= pulseCnt_next;
            syncRequestOut_n_reg <= (state_next == serial_link_error_monitor_pkg::SYNC_UP)
                                 && pulseCnt_next == 3'h0;
            linkOkPrev_reg <= linkOkNow;
            // Set wins over a same-cycle clear; reinit does not touch it
            irqStat_reg <= (irqStat_reg & ~irqClear) | (irqEvent & irqEnAll);
        end
    end

    assign syncRequestOut_n = syncRequestOut_n_reg;

endmodule
`default_nettype wire

// ==== bench/serial_link_error_monitor_assertions.sv ====
// Purpose: port checks for the error monitor
// Assumes: zero wait APB, sync request active low
// Notes: bound to the top module
`include "serial_link_error_monitor_defs.svh"
`default_nettype none
module serial_link_error_monitor_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Link
    input wire serial_link_error_monitor_pkg::lane_chars_t laneChars,
    input wire serial_link_error_monitor_pkg::link_status_t linkStatus,
    input wire logic syncRequestOut_n,
    input wire logic irqPending
);
    wire allComma = (laneChars.comma & linkStatus.laneActive) == linkStatus.laneActive;
    wire anyErr = |((laneChars.disparityError | laneChars.notInTableError
        | laneChars.unexpectedControlCharError) & linkStatus.laneActive);
    wire stWr = psel && penable && pwrite
        && (paddr[13:2] == `REG_IRQ_ST0 || paddr[13:2] == `REG_IRQ_ST1);
    // Error pulses last at most seven cycles; a longer low is a resync
    logic [7:0] lowRun_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || syncRequestOut_n) begin
            lowRun_reg <= 8'h00;
        end else if (lowRun_reg != 8'hff) begin
            lowRun_reg <= 8'(lowRun_reg + 8'h01);
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_slverr_phase: assert property (pslverr |-> psel && penable) else $error("pslverr early");
    chk_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("prdata moved");
    chk_reset_sync: assert property ($rose(rst_n) |-> !syncRequestOut_n)
        else $error("sync not requested after reset");
    chk_reset_irq: assert property ($rose(rst_n) |-> !irqPending) else $error("irq after reset");
    chk_sync_release: assert property ($rose(syncRequestOut_n) && lowRun_reg > 8'h07 |->
        $past(allComma, 1) && $past(allComma, 2) && $past(allComma, 3) && $past(allComma, 4))
        else $error("sync released early");
    chk_error_pulse: assert property (syncRequestOut_n && anyErr
        |-> ##[1:2] !syncRequestOut_n) else $error("no error pulse");
    chk_irq_clear: assert property ($fell(irqPending) |-> $past(stWr))
        else $error("irq cleared without write");
    cover property ($rose(syncRequestOut_n));
    cover property ($fell(irqPending));
    cover property (pslverr);
endmodule
bind serial_link_error_monitor serial_link_error_monitor_assertions chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .laneChars(laneChars), .linkStatus(linkStatus),
    .syncRequestOut_n(syncRequestOut_n), .irqPending(irqPending));
`default_nettype wire

// ==== bench/link_transmitter_model.sv ====
// Purpose: transmitter facing the receiver lanes
// Assumes: one character per lane per cycle
// Notes: errors only when the bench asks
`default_nettype none
module link_transmitter_model (
    // Clock
    input wire logic sys_clk,
    // Bench commands
    input wire logic [7:0] activeLanes,
    input wire logic [2:0] errKind,
    input wire logic [7:0] errLanes,
    // Receiver side
    input wire logic syncRequestOut_n,
    output var serial_link_error_monitor_pkg::lane_chars_t laneChars,
    output var serial_link_error_monitor_pkg::link_status_t linkStatus
);
    // Commas while sync is requested, repeated alignment after release
    always_comb begin
        laneChars.comma = syncRequestOut_n ? 8'h00 : 8'hff;
        laneChars.disparityError = errKind[2] ? errLanes : 8'h00;
        laneChars.notInTableError = errKind[1] ? errLanes : 8'h00;
        laneChars.unexpectedControlCharError = errKind[0] ? errLanes : 8'h00;
        linkStatus.laneActive = activeLanes;
        linkStatus.frameSync = syncRequestOut_n ? activeLanes : 8'h00;
        linkStatus.goodChecksum = linkStatus.frameSync;
        linkStatus.ilasPass = linkStatus.frameSync;
        linkStatus.deskewDone = syncRequestOut_n;
    end
endmodule
`default_nettype wire

// ==== bench/serial_link_error_monitor_bench.sv ====
// Purpose: self-checking bench for the error monitor
// Assumes: F of one, pulse duration zero
// Notes: registers reached over APB
`include "serial_link_error_monitor_defs.svh"
`default_nettype none
module serial_link_error_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, syncRequestOut_n, irqPending, err;
    logic [7:0] errLanes = 8'h00, lowCnt;
    logic [2:0] errKind = 3'h0;
    serial_link_error_monitor_pkg::lane_chars_t laneChars;
    serial_link_error_monitor_pkg::link_status_t linkStatus;
    serial_link_error_monitor_pkg::link_cfg_t linkCfg = '0;
    int fail_count = 0, n_compared = 0;
    serial_link_error_monitor dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .laneChars(laneChars),
        .linkStatus(linkStatus), .linkCfg(linkCfg),
        .syncRequestOut_n(syncRequestOut_n), .irqPending(irqPending));
    link_transmitter_model tx (.sys_clk(sys_clk), .activeLanes(8'hff), .errKind(errKind),
        .errLanes(errLanes), .syncRequestOut_n(syncRequestOut_n),
        .laneChars(laneChars), .linkStatus(linkStatus));
    ////////////////
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask
    // Low cycles counted over a window long enough for a resync
    task automatic inject(input logic [2:0] kind, input logic [7:0] lanes);
        @(posedge sys_clk);
        errKind <= kind;
        errLanes <= lanes;
        @(posedge sys_clk);
        errKind <= 3'h0;
        lowCnt = 8'h00;
        repeat (24) begin
            @(posedge sys_clk);
            if (syncRequestOut_n === 1'b0) lowCnt++;
        end
    endtask
    task automatic waitUp;
        int n = 0;
        while (syncRequestOut_n !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, syncRequestOut_n}, 32'h1);
    endtask
    ////////////////
    task automatic test_reset_values;
        rdChk(`REG_THR, 32'hff);
        rdChk(`REG_MASK, 32'h7);
        rdChk(`REG_IRQ_EN0, 32'h0);
        rdChk(`REG_IRQ_EN1, 32'h0);
        for (int l = 0; l < 8; l++) rdChk(`REG_LANE_CTRL + 12'(l), 32'h38);
        xfer(1'b1, `REG_MASK, 32'h0);
        rdChk(`REG_MASK, 32'h7);
        xfer(1'b0, 12'h7ff, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task automatic test_link_up;
        xfer(1'b1, `REG_LINK_PAGE, 32'h4);
        xfer(1'b1, `REG_MASK, 32'h0);
        rdChk(`REG_MASK, 32'h0);
        xfer(1'b1, `REG_IRQ_EN0, 32'he0);
        xfer(1'b1, `REG_ERR_DUR, 32'h0);
        xfer(1'b1, `REG_TEST, 32'h80);
        xfer(1'b1, `REG_LINK_CTRL, 32'h11);
        waitUp;
        rdChk(`REG_CGS, 32'hff);
        rdChk(`REG_ILAS, 32'hff);
        xfer(1'b1, `REG_IRQ_ST0, 32'hff);
    endtask
    task automatic test_threshold;
        xfer(1'b1, `REG_THR, 32'h3);
        inject(3'b001, 8'h01);
        check({24'h0, lowCnt}, 32'h1);
        inject(3'b001, 8'h01);
        rdChk(`REG_LANE_STAT, 32'h8);
        inject(3'b001, 8'h01);
        rdChk(`REG_LANE_STAT, 32'h9);
        xfer(1'b0, `REG_IRQ_ST0, 32'h0);
        check(rd & 32'he0, 32'h20);
        check({31'h0, irqPending}, 32'h1);
        xfer(1'b1, `REG_IRQ_ST0, 32'h20);
        xfer(1'b0, `REG_IRQ_ST0, 32'h0);
        check(rd & 32'he0, 32'h0);
        xfer(1'b1, `REG_LANE_CTRL, 32'h39);
        rdChk(`REG_LANE_STAT, 32'h8);
        xfer(1'b1, `REG_LANE_CTRL, 32'h30);
        for (int i = 0; i < 3; i++) inject(3'b001, 8'h01);
        rdChk(`REG_LANE_STAT, 32'h8);
    endtask
    task automatic test_reinit;
        for (int i = 0; i < 3; i++) inject(3'b010, 8'h02);
        rdChk(`REG_LANE_STAT + 12'h1, 32'ha);
        inject(3'b010, 8'h02);
        check({31'h0, lowCnt >= 8'h04}, 32'h1);
        waitUp;
        rdChk(`REG_LANE_STAT + 12'h1, 32'h8);
        xfer(1'b0, `REG_IRQ_ST0, 32'h0);
        check(rd & 32'he0, 32'h40);
    endtask
    task automatic test_qualify;
        xfer(1'b1, `REG_QUAL, 32'h10);
        xfer(1'b1, `REG_THR, 32'h1);
        inject(3'b110, 8'h04);
        rdChk(`REG_LANE_STAT + 12'h2, 32'ha);
        inject(3'b100, 8'h04);
        rdChk(`REG_LANE_STAT + 12'h2, 32'he);
    endtask
    // Threshold zero is only reached by a wrap, so a held counter never flags
    task automatic test_hold;
        xfer(1'b1, `REG_THR, 32'h0);
        xfer(1'b1, `REG_LANE_HOLD + 12'h3, 32'h1);
        @(posedge sys_clk);
        errKind <= 3'b001;
        errLanes <= 8'h18;
        repeat (260) @(posedge sys_clk);
        errKind <= 3'h0;
        rdChk(`REG_LANE_STAT + 12'h3, 32'h8);
        rdChk(`REG_LANE_STAT + 12'h4, 32'h9);
    endtask
    task automatic test_mismatch;
        xfer(1'b1, `REG_IRQ_EN1, 32'h1);
        linkCfg.received <= 112'h1;
        rdChk(`REG_IRQ_ST1, 32'h1);
    endtask
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // Run needs under a thousand cycles; this leaves ample margin
    initial begin
        #60000;
        fail_count++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_reset_values;
        test_link_up;
        test_threshold;
        test_reinit;
        test_qualify;
        test_hold;
        test_mismatch;
        final_report;
    end
endmodule
`default_nettype wire
